//--- hdl/ssu_pkg.sv
// constants shared by the synchronous serial unit
package ssu_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_TX_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] OFF_RX_STATUS_CONTROL = 8'h04;
  localparam logic [7:0] OFF_TX_DATA = 8'h08;
  localparam logic [7:0] OFF_RX_DATA = 8'h0c;
  localparam logic [7:0] OFF_BAUD_DIVISOR = 8'h10;
  localparam logic [7:0] OFF_PERIPH_INT_ENABLE_1 = 8'h14;
  localparam logic [7:0] OFF_PERIPH_INT_FLAGS_1 = 8'h18;
  localparam logic [7:0] OFF_CORE_INT_CONTROL = 8'h1c;
  localparam logic [7:0] OFF_SEGMENT_ENABLE_HI = 8'h20;
  // tx_status_control fields
  localparam int TX_CLOCK_SOURCE_MASTER = 7;
  localparam int TX_NINE_BIT_ENABLE = 6;
  localparam int TX_ENABLE = 5;
  localparam int TX_SYNC_MODE = 4;
  localparam int TX_HIGH_BAUD_SELECT = 2;
  localparam int TX_SHIFT_EMPTY = 1;
  localparam int TX_NINTH_BIT = 0;
  // rx_status_control fields
  localparam int RX_PORT_ENABLE = 7;
  localparam int RX_NINE_BIT_ENABLE = 6;
  localparam int RX_SINGLE_ENABLE = 5;
  localparam int RX_CONTINUOUS_ENABLE = 4;
  localparam int RX_ADDR_DETECT_ENABLE = 3;
  localparam int RX_OVERRUN_FLAG = 1;
  localparam int RX_NINTH_BIT = 0;
  // interrupt enable / flag fields
  localparam int INT_RX = 5;
  localparam int INT_TX = 4;
  localparam int CORE_GLOBAL_INT_ENABLE = 7;
  localparam int CORE_PERIPHERAL_INT_ENABLE = 6;
  // reset values
  localparam logic [7:0] TX_STATUS_CONTROL_RESET = 8'h02;
  localparam logic [7:0] RX_STATUS_CONTROL_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  // character lengths and buffer depth
  localparam logic [3:0] CHAR_BITS_8 = 4'h8;
  localparam logic [3:0] CHAR_BITS_9 = 4'h9;
  localparam int RX_FIFO_DEPTH = 2;
  localparam int CHAR_WIDTH = 9;
  typedef enum logic [1:0] {MR_IDLE, MR_LOW, MR_HIGH} ssu_mrx_state_t;
endpackage

//--- hdl/ssu_baud.sv
// line clock tick generator for master mode
`timescale 1ns/1ps
module ssu_baud import ssu_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic run,
  input wire logic high_baud_select,
  input wire logic [7:0] baud_divisor,
  output logic tick
);
  logic [9:0] cnt_ff;
  logic [9:0] limit;

  // low speed stretches each half period by four
  assign limit = high_baud_select ? {2'b00, baud_divisor} : {baud_divisor, 2'b11};
  assign tick = run && (cnt_ff == limit);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 10'h000;
    end else if (ce) begin
      if (!run || tick) begin
        cnt_ff <= 10'h000;
      end else begin
        cnt_ff <= cnt_ff + 10'h001;
      end
    end
  end
endmodule // ssu_baud

//--- hdl/ssu_rxfifo.sv
// two character receive buffer
`timescale 1ns/1ps
module ssu_rxfifo import ssu_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic flush,
  input wire logic push,
  input wire logic [CHAR_WIDTH-1:0] push_data,
  input wire logic pop,
  output logic full,
  output logic empty,
  output logic [CHAR_WIDTH-1:0] top
);
  logic [CHAR_WIDTH-1:0] mem [0:RX_FIFO_DEPTH-1];
  logic rd_ptr_ff;
  logic wr_ptr_ff;
  logic [1:0] cnt_ff;
  logic do_push;
  logic do_pop;

  assign full = (cnt_ff == 2'h2);
  assign empty = (cnt_ff == 2'h0);
  assign top = mem[rd_ptr_ff];
  assign do_push = push && !full;
  assign do_pop = pop && !empty;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_ptr_ff <= 1'b0;
      wr_ptr_ff <= 1'b0;
      cnt_ff <= 2'h0;
    end else if (ce) begin
      if (flush) begin
        rd_ptr_ff <= 1'b0;
        wr_ptr_ff <= 1'b0;
        cnt_ff <= 2'h0;
      end else begin
        if (do_push) begin
          wr_ptr_ff <= !wr_ptr_ff;
        end
        if (do_pop) begin
          rd_ptr_ff <= !rd_ptr_ff;
        end
        cnt_ff <= cnt_ff + {1'b0, do_push} - {1'b0, do_pop};
      end
    end
  end

  always_ff @(posedge pclk) begin
    if (ce && do_push && !flush) begin
      mem[wr_ptr_ff] <= push_data;
    end
  end
endmodule // ssu_rxfifo

//--- hdl/ssu_top.sv
// synchronous serial unit: master receive, slave transmit and receive, apb registers
`timescale 1ns/1ps
module ssu_top import ssu_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic data_line_i,
  output logic data_line_o,
  output logic data_line_oe,
  input wire logic clock_line_i,
  output logic clock_line_o,
  output logic clock_line_oe,
  output logic irq_o,
  output logic vector_o
);
  function automatic logic [3:0] char_bits(input logic nine);
    char_bits = nine ? CHAR_BITS_9 : CHAR_BITS_8;
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic clock_source_master_ff, tx9_ff, tx_enable_ff, sync_ff, high_baud_select_ff, tx_ninth_bit_ff;
  logic port_enable_ff, rx9_ff, single_rx_enable_ff, continuous_rx_enable_ff, addr_detect_enable_ff, overrun_flag_ff;
  logic rx_int_enable_ff, tx_int_enable_ff, gie_ff, peripheral_int_enable_ff;
  logic [7:0] divisor_ff;
  logic [7:0] seg_ff;
  logic [31:0] prdata_ff;
  logic pready_ff, pslverr_ff;
  logic irq_ff, vector_ff;
  logic access, wr_en, rd_en, mapped;
  logic wr_tx, wr_rc, rd_rx;

  assign access = psel && penable && pready_ff;
  assign wr_en = access && pwrite;
  assign rd_en = access && !pwrite;
  assign wr_tx = wr_en && (paddr == OFF_TX_DATA);
  assign wr_rc = wr_en && (paddr == OFF_RX_STATUS_CONTROL);
  assign rd_rx = rd_en && (paddr == OFF_RX_DATA);
  assign mapped = (paddr == OFF_TX_STATUS_CONTROL) || (paddr == OFF_RX_STATUS_CONTROL) ||
                  (paddr == OFF_TX_DATA) || (paddr == OFF_RX_DATA) ||
                  (paddr == OFF_BAUD_DIVISOR) || (paddr == OFF_PERIPH_INT_ENABLE_1) ||
                  (paddr == OFF_PERIPH_INT_FLAGS_1) || (paddr == OFF_CORE_INT_CONTROL) ||
                  (paddr == OFF_SEGMENT_ENABLE_HI);

  // ----------------------------------------------------------------
  // pin synchronisers and modes
  // ----------------------------------------------------------------
  logic clk_s1_ff, clk_s2_ff, clk_s3_ff, dat_s1_ff, dat_s2_ff;
  logic clk_rise, clk_fall;
  logic unit_on, master, slave, rx_req, master_rx, slave_rx, slave_tx, rx_go;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_s1_ff <= 1'b0;
      clk_s2_ff <= 1'b0;
      clk_s3_ff <= 1'b0;
      dat_s1_ff <= 1'b0;
      dat_s2_ff <= 1'b0;
    end else if (ce) begin
      clk_s1_ff <= clock_line_i;
      clk_s2_ff <= clk_s1_ff;
      clk_s3_ff <= clk_s2_ff;
      dat_s1_ff <= data_line_i;
      dat_s2_ff <= dat_s1_ff;
    end
  end

  assign clk_rise = clk_s2_ff && !clk_s3_ff;
  assign clk_fall = !clk_s2_ff && clk_s3_ff;
  assign unit_on = port_enable_ff && sync_ff;
  assign master = unit_on && clock_source_master_ff;
  assign slave = unit_on && !clock_source_master_ff;
  assign rx_req = single_rx_enable_ff || continuous_rx_enable_ff;
  assign master_rx = master && rx_req;
  assign slave_rx = slave && rx_req;
  assign slave_tx = slave && !rx_req && tx_enable_ff;
  assign rx_go = (master_rx || slave_rx) && !overrun_flag_ff;

  // ----------------------------------------------------------------
  // master line clock
  // ----------------------------------------------------------------
  ssu_mrx_state_t mstate_ff;
  logic tick, mclk_ff, samp, last, complete;
  logic [3:0] rcnt_ff;
  logic [8:0] rsr_ff, nxt_rsr, rx_char;
  logic fifo_full, fifo_empty;
  logic [8:0] fifo_top;

  ssu_baud u_baud (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .run(master_rx && !overrun_flag_ff),
    .high_baud_select(high_baud_select_ff),
    .baud_divisor(divisor_ff),
    .tick(tick)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mstate_ff <= MR_IDLE;
      mclk_ff <= 1'b0;
    end else if (ce) begin
      case (mstate_ff)
        MR_IDLE: begin
          mclk_ff <= 1'b0;
          if (master_rx && !overrun_flag_ff) begin
            mstate_ff <= MR_LOW;
          end
        end
        MR_LOW: begin
          if (!master_rx || overrun_flag_ff) begin
            mstate_ff <= MR_IDLE;
          end else if (tick) begin
            mclk_ff <= 1'b1;
            mstate_ff <= MR_HIGH;
          end
        end
        default: begin
          // clock stops at once when reception is withdrawn
          if (!master_rx || overrun_flag_ff) begin
            mclk_ff <= 1'b0;
            mstate_ff <= MR_IDLE;
          end else if (tick) begin
            mclk_ff <= 1'b0;
            mstate_ff <= MR_LOW;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // receive shifter
  // ----------------------------------------------------------------
  assign samp = rx_go && (master ? (tick && mstate_ff == MR_HIGH) : clk_fall);
  assign nxt_rsr = {dat_s2_ff, rsr_ff[8:1]};
  assign last = (rcnt_ff == char_bits(rx9_ff) - 4'h1);
  assign complete = samp && last;
  assign rx_char = rx9_ff ? nxt_rsr : {1'b0, nxt_rsr[8:1]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsr_ff <= 9'h000;
      rcnt_ff <= 4'h0;
    end else if (ce) begin
      if (!rx_go) begin
        // partial character is discarded
        rcnt_ff <= 4'h0;
      end else if (samp) begin
        rsr_ff <= nxt_rsr;
        rcnt_ff <= last ? 4'h0 : rcnt_ff + 4'h1;
      end
    end
  end

  ssu_rxfifo u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .flush(!port_enable_ff),
    .push(complete),
    .push_data(rx_char),
    .pop(rd_rx),
    .full(fifo_full),
    .empty(fifo_empty),
    .top(fifo_top)
  );

  // ----------------------------------------------------------------
  // slave transmitter
  // ----------------------------------------------------------------
  logic [8:0] hold_ff, tsr_ff;
  logic hold_full_ff, tsr_full_ff, dout_ff, doe_ff;
  logic [3:0] tcnt_ff;
  logic tx_done, tsr_free;

  assign tx_done = slave_tx && tsr_full_ff && clk_fall &&
                   (tcnt_ff == char_bits(tx9_ff) - 4'h1);
  assign tsr_free = !tsr_full_ff || (tx_done && !hold_full_ff);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_ff <= 9'h000;
      tsr_ff <= 9'h000;
      hold_full_ff <= 1'b0;
      tsr_full_ff <= 1'b0;
      tcnt_ff <= 4'h0;
      dout_ff <= 1'b0;
    end else if (ce) begin
      if (!port_enable_ff) begin
        hold_full_ff <= 1'b0;
        tsr_full_ff <= 1'b0;
        tcnt_ff <= 4'h0;
        dout_ff <= 1'b0;
      end else begin
        if (slave_tx && tsr_full_ff && clk_rise) begin
          dout_ff <= tsr_ff[0];
        end
        if (tx_done && hold_full_ff) begin
          tsr_ff <= hold_ff;
          hold_full_ff <= wr_tx;
          tcnt_ff <= 4'h0;
        end else if (tx_done) begin
          tsr_full_ff <= 1'b0;
          tcnt_ff <= 4'h0;
        end else if (slave_tx && tsr_full_ff && clk_fall) begin
          tsr_ff <= {1'b0, tsr_ff[8:1]};
          tcnt_ff <= tcnt_ff + 4'h1;
        end
        if (wr_tx && tsr_free) begin
          tsr_ff <= {tx_ninth_bit_ff, pwdata[7:0]};
          tsr_full_ff <= 1'b1;
          tcnt_ff <= 4'h0;
        end else if (wr_tx) begin
          hold_ff <= {tx_ninth_bit_ff, pwdata[7:0]};
          hold_full_ff <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic ovr_set;
  assign ovr_set = complete && fifo_full;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {clock_source_master_ff, tx9_ff, tx_enable_ff, sync_ff} <= TX_STATUS_CONTROL_RESET[7:4];
      high_baud_select_ff <= TX_STATUS_CONTROL_RESET[TX_HIGH_BAUD_SELECT];
      tx_ninth_bit_ff <= TX_STATUS_CONTROL_RESET[TX_NINTH_BIT];
      {port_enable_ff, rx9_ff, single_rx_enable_ff, continuous_rx_enable_ff, addr_detect_enable_ff} <= RX_STATUS_CONTROL_RESET[7:3];
      divisor_ff <= BYTE_RESET;
      seg_ff <= BYTE_RESET;
      {rx_int_enable_ff, tx_int_enable_ff, gie_ff, peripheral_int_enable_ff} <= 4'h0;
    end else if (ce) begin
      if (wr_en && paddr == OFF_TX_STATUS_CONTROL) begin
        clock_source_master_ff <= pwdata[TX_CLOCK_SOURCE_MASTER];
        tx9_ff <= pwdata[TX_NINE_BIT_ENABLE];
        tx_enable_ff <= pwdata[TX_ENABLE];
        sync_ff <= pwdata[TX_SYNC_MODE];
        high_baud_select_ff <= pwdata[TX_HIGH_BAUD_SELECT];
        tx_ninth_bit_ff <= pwdata[TX_NINTH_BIT];
      end
      if (wr_rc) begin
        port_enable_ff <= pwdata[RX_PORT_ENABLE];
        rx9_ff <= pwdata[RX_NINE_BIT_ENABLE];
        continuous_rx_enable_ff <= pwdata[RX_CONTINUOUS_ENABLE];
        addr_detect_enable_ff <= pwdata[RX_ADDR_DETECT_ENABLE];
        single_rx_enable_ff <= pwdata[RX_SINGLE_ENABLE];
      end else if (master && complete) begin
        single_rx_enable_ff <= 1'b0;
      end
      if (wr_en && paddr == OFF_BAUD_DIVISOR) begin
        divisor_ff <= pwdata[7:0];
      end
      if (wr_en && paddr == OFF_SEGMENT_ENABLE_HI) begin
        seg_ff <= pwdata[7:0];
      end
      if (wr_en && paddr == OFF_PERIPH_INT_ENABLE_1) begin
        rx_int_enable_ff <= pwdata[INT_RX];
        tx_int_enable_ff <= pwdata[INT_TX];
      end
      if (wr_en && paddr == OFF_CORE_INT_CONTROL) begin
        gie_ff <= pwdata[CORE_GLOBAL_INT_ENABLE];
        peripheral_int_enable_ff <= pwdata[CORE_PERIPHERAL_INT_ENABLE];
      end
    end
  end

  // overrun: a new overrun wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun_flag_ff <= 1'b0;
    end else if (ce) begin
      if (ovr_set) begin
        overrun_flag_ff <= 1'b1;
      end else if (!port_enable_ff || (wr_rc && continuous_rx_enable_ff && !pwdata[RX_CONTINUOUS_ENABLE]) ||
                   (rd_rx && !continuous_rx_enable_ff)) begin
        overrun_flag_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else if (ce) begin
      pready_ff <= psel && !penable;
      pslverr_ff <= psel && !penable && !mapped;
      prdata_ff <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        if (paddr == OFF_TX_STATUS_CONTROL) begin
          prdata_ff[7:0] <= {clock_source_master_ff, tx9_ff, tx_enable_ff, sync_ff, 1'b0, high_baud_select_ff,
                             !tsr_full_ff, tx_ninth_bit_ff};
        end else if (paddr == OFF_RX_STATUS_CONTROL) begin
          prdata_ff[7:0] <= {port_enable_ff, rx9_ff, single_rx_enable_ff, continuous_rx_enable_ff, addr_detect_enable_ff, 1'b0,
                             overrun_flag_ff, fifo_top[8] && !fifo_empty};
        end else if (paddr == OFF_RX_DATA) begin
          prdata_ff[7:0] <= fifo_empty ? BYTE_RESET : fifo_top[7:0];
        end else if (paddr == OFF_BAUD_DIVISOR) begin
          prdata_ff[7:0] <= divisor_ff;
        end else if (paddr == OFF_PERIPH_INT_ENABLE_1) begin
          prdata_ff[INT_RX] <= rx_int_enable_ff;
          prdata_ff[INT_TX] <= tx_int_enable_ff;
        end else if (paddr == OFF_PERIPH_INT_FLAGS_1) begin
          prdata_ff[INT_RX] <= !fifo_empty;
          prdata_ff[INT_TX] <= !hold_full_ff;
        end else if (paddr == OFF_CORE_INT_CONTROL) begin
          prdata_ff[CORE_GLOBAL_INT_ENABLE] <= gie_ff;
          prdata_ff[CORE_PERIPHERAL_INT_ENABLE] <= peripheral_int_enable_ff;
        end else if (paddr == OFF_SEGMENT_ENABLE_HI) begin
          prdata_ff[7:0] <= seg_ff;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // pins and wake request
  // ----------------------------------------------------------------
  logic cmclk_ff, coe_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      doe_ff <= 1'b0;
      coe_ff <= 1'b0;
      cmclk_ff <= 1'b0;
      irq_ff <= 1'b0;
      vector_ff <= 1'b0;
    end else if (ce) begin
      doe_ff <= slave_tx;
      coe_ff <= master;
      cmclk_ff <= mclk_ff;
      irq_ff <= peripheral_int_enable_ff && ((!fifo_empty && rx_int_enable_ff) || (!hold_full_ff && tx_int_enable_ff));
      vector_ff <= gie_ff && peripheral_int_enable_ff &&
                   ((!fifo_empty && rx_int_enable_ff) || (!hold_full_ff && tx_int_enable_ff));
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign data_line_o = dout_ff;
  assign data_line_oe = doe_ff;
  assign clock_line_o = cmclk_ff;
  assign clock_line_oe = coe_ff;
  assign irq_o = irq_ff;
  assign vector_o = vector_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_SINGLE_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
    ce && master && complete && !wr_rc |=> !single_rx_enable_ff)
    else $error("single receive enable not cleared after character");
  AST_FLAG_ON_CHAR: assert property (@(posedge pclk) disable iff (!presetn)
    ce && complete && !fifo_full && port_enable_ff |=> !fifo_empty)
    else $error("receive flag not set after complete character");
  AST_OVERRUN_SET: assert property (@(posedge pclk) disable iff (!presetn)
    ce && complete && fifo_full |=> overrun_flag_ff && fifo_full)
    else $error("overrun missing or buffer disturbed");
  AST_OVERRUN_BLOCKS: assert property (@(posedge pclk) disable iff (!presetn)
    overrun_flag_ff |-> !samp)
    else $error("reception continued during overrun");
  AST_CONT_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    ce && wr_rc && continuous_rx_enable_ff && !pwdata[RX_CONTINUOUS_ENABLE] && !ovr_set |=> !overrun_flag_ff)
    else $error("overrun not cleared by continuous enable clear");
  AST_PORT_RESET: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !port_enable_ff |=> fifo_empty && !tsr_full_ff && !hold_full_ff)
    else $error("port disable did not reset unit");
  AST_SLAVE_NO_CLOCK: assert property (@(posedge pclk) disable iff (!presetn)
    ce && slave ##1 ce |=> !clock_line_oe)
    else $error("slave drives clock line");
  AST_RX_NO_DRIVE: assert property (@(posedge pclk) disable iff (!presetn)
    ce && rx_req |=> !data_line_oe)
    else $error("data line driven while receiving");
  AST_SECOND_WAITS: assert property (@(posedge pclk) disable iff (!presetn)
    ce && wr_tx && tsr_full_ff && !tx_done && port_enable_ff |=> hold_full_ff && tsr_full_ff)
    else $error("second word not held");
  AST_HOLD_MOVES: assert property (@(posedge pclk) disable iff (!presetn)
    ce && tx_done && hold_full_ff && !wr_tx |=>
    (tsr_full_ff && !hold_full_ff) ##1 (irq_o || !$past(peripheral_int_enable_ff && tx_int_enable_ff)))
    else $error("held word not moved or transmit flag not raised");
  AST_LEADING_EDGE: assert property (@(posedge pclk) disable iff (!presetn)
    ce && slave_tx && tsr_full_ff && clk_rise && port_enable_ff |=> data_line_o == $past(tsr_ff[0]))
    else $error("slave data not presented on leading edge");
endmodule // ssu_top

//--- bench/ssu_partner.sv
// far-side synchronous serial partner model
`timescale 1ns/1ps
module ssu_partner (
  input wire logic go,
  input wire logic [3:0] nbits,
  input wire logic [8:0] word,
  input wire logic mclk,
  input wire logic dat_i,
  output logic sclk,
  output logic dat_o,
  output logic [8:0] got,
  output logic busy
);
  int k = 0;
  initial begin
    sclk = 1'b0;
    dat_o = 1'b0;
    got = 9'h000;
    busy = 1'b0;
  end
  // partner-clocked frame: drive on leading, sample on trailing
  always @(posedge go) begin
    busy = 1'b1;
    // keep pin edges off the sampling edge of pclk
    #3;
    for (int i = 0; i < nbits; i++) begin
      sclk = 1'b1;
      dat_o = word[i];
      #80;
      sclk = 1'b0;
      got[i] = dat_i;
      #80;
    end
    busy = 1'b0;
    dat_o = ~dat_o;
  end
  // device-clocked frame: next bit on each leading edge
  always @(posedge mclk) begin
    dat_o = word[k];
    k = (k + 1 == nbits) ? 0 : k + 1;
  end
endmodule // ssu_partner

//--- bench/sync_serial_master_slave_rx_tx_tb_top.sv
// self-checking bench for the synchronous serial unit
`timescale 1ns/1ps
module sync_serial_master_slave_rx_tx_tb_top import ssu_pkg::*;;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0, rerr;
  logic [7:0] paddr = 8'h00, rdat, seg;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic [3:0] nbits = 4'h8;
  logic [8:0] word = 9'h000, w0, w1, p_got;
  logic pready, pslverr, dlo, dloe, clo, cloe, irq, vec, p_sclk, p_dat, p_busy;
  int mismatches = 0, n_compared = 0, cyc = 0;
  wire dl = dloe ? dlo : p_dat;
  wire cl = cloe ? clo : p_sclk;
  always #5 pclk = ~pclk;
  ssu_top dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .data_line_i(dl), .data_line_o(dlo), .data_line_oe(dloe),
    .clock_line_i(cl), .clock_line_o(clo), .clock_line_oe(cloe), .irq_o(irq), .vector_o(vec));
  ssu_partner partner (.go(go), .nbits(nbits), .word(word), .mclk(cloe & clo), .dat_i(dl),
    .sclk(p_sclk), .dat_o(p_dat), .got(p_got), .busy(p_busy));
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      mismatches++;
      results;
    end
  end
  task automatic chk(input string nm, input logic [8:0] exp, input logic [8:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata[7:0];
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(0, a, 8'h00);
  endtask
  task automatic waitf(input int b);
    rd(OFF_PERIPH_INT_FLAGS_1);
    for (int i = 0; i < 300 && rdat[b] !== 1'b1; i++) rd(OFF_PERIPH_INT_FLAGS_1);
  endtask
  task automatic frame(input logic [8:0] w);
    word <= w;
    @(posedge pclk);
    go <= 1;
    @(posedge pclk);
    go <= 0;
    wait (p_busy === 1'b0);
    repeat (8) @(posedge pclk);
  endtask
  initial begin
    void'($urandom(16789));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFF_TX_STATUS_CONTROL);
    chk("tx_status", {1'b0, TX_STATUS_CONTROL_RESET}, {1'b0, rdat});
    rd(OFF_RX_STATUS_CONTROL);
    chk("rx_status", {1'b0, RX_STATUS_CONTROL_RESET}, {1'b0, rdat});
    rd(8'hfc);
    chk("unmapped", 9'h001, {8'h00, rerr});
    seg = 8'($urandom) & 8'hfc;
    wr(OFF_SEGMENT_ENABLE_HI, seg);
    rd(OFF_SEGMENT_ENABLE_HI);
    chk("segment", {1'b0, seg}, {1'b0, rdat});
    $display("test reset done");
    w0 = 9'($urandom);
    word <= {1'b0, w0[7:0]};
    wr(OFF_BAUD_DIVISOR, 8'h07);
    wr(OFF_PERIPH_INT_ENABLE_1, 8'h20);
    wr(OFF_CORE_INT_CONTROL, 8'hc0);
    wr(OFF_TX_STATUS_CONTROL, 8'h94);
    wr(OFF_RX_STATUS_CONTROL, 8'h80);
    wr(OFF_RX_STATUS_CONTROL, 8'ha0);
    waitf(INT_RX);
    chk("irq_rx", 9'h001, {8'h00, irq});
    chk("vector_rx", 9'h001, {8'h00, vec});
    rd(OFF_RX_STATUS_CONTROL);
    chk("single_clear", 9'h080, {1'b0, rdat});
    rd(OFF_RX_DATA);
    chk("master_rx", {1'b0, w0[7:0]}, {1'b0, rdat});
    w0 = 9'($urandom);
    word <= w0;
    nbits <= 4'h9;
    wr(OFF_BAUD_DIVISOR, 8'h01);
    wr(OFF_TX_STATUS_CONTROL, 8'h90);
    wr(OFF_RX_STATUS_CONTROL, 8'hc0);
    wr(OFF_RX_STATUS_CONTROL, 8'he0);
    waitf(INT_RX);
    rd(OFF_RX_STATUS_CONTROL);
    chk("master_status9", {1'b0, 7'h60, w0[8]}, {1'b0, rdat});
    rd(OFF_RX_DATA);
    chk("master_rx9", {1'b0, w0[7:0]}, {1'b0, rdat});
    $display("test master receive done");
    wr(OFF_TX_STATUS_CONTROL, 8'h10);
    wr(OFF_RX_STATUS_CONTROL, 8'hf0);
    w0 = 9'($urandom);
    w1 = 9'($urandom);
    frame(w0);
    chk("wake_rx", 9'h001, {8'h00, irq});
    frame(w1);
    frame(~w0);
    rd(OFF_RX_STATUS_CONTROL);
    chk("overrun_ninth", {7'h00, 1'b1, w0[8]}, {7'h00, rdat[1:0]});
    rd(OFF_RX_DATA);
    chk("rx_first", {1'b0, w0[7:0]}, {1'b0, rdat});
    rd(OFF_RX_STATUS_CONTROL);
    chk("ninth_second", {8'h00, w1[8]}, {8'h00, rdat[0]});
    rd(OFF_RX_DATA);
    chk("rx_second", {1'b0, w1[7:0]}, {1'b0, rdat});
    wr(OFF_RX_STATUS_CONTROL, 8'hc0);
    rd(OFF_RX_STATUS_CONTROL);
    chk("overrun_clear", 9'h000, {8'h00, rdat[1]});
    $display("test slave receive done");
    wr(OFF_RX_STATUS_CONTROL, 8'h80);
    wr(OFF_PERIPH_INT_ENABLE_1, 8'h10);
    wr(OFF_TX_STATUS_CONTROL, {7'h38, w0[8]});
    wr(OFF_TX_DATA, w0[7:0]);
    wr(OFF_TX_STATUS_CONTROL, {7'h38, w1[8]});
    wr(OFF_TX_DATA, w1[7:0]);
    rd(OFF_PERIPH_INT_FLAGS_1);
    chk("tx_flag_held", 9'h000, {8'h00, rdat[INT_TX]});
    frame(9'h000);
    chk("tx_first", w0, p_got);
    rd(OFF_PERIPH_INT_FLAGS_1);
    chk("tx_flag_set", 9'h001, {8'h00, rdat[INT_TX]});
    chk("wake_tx", 9'h001, {8'h00, irq});
    frame(9'h000);
    chk("tx_second", w1, p_got);
    wr(OFF_TX_DATA, w0[7:0]);
    wr(OFF_RX_STATUS_CONTROL, 8'h00);
    rd(OFF_TX_STATUS_CONTROL);
    chk("port_off", {1'b0, 7'h39, w1[8]}, {1'b0, rdat});
    $display("test slave transmit done");
    results;
  end
endmodule // sync_serial_master_slave_rx_tx_tb_top
